// ==== clkrdy_pkg.sv ====
// Shared constants and types of the clock readiness status block
package clkrdy_pkg;

   localparam int DATA_W = 32;
   localparam int ADR_W = 8;
   localparam int SEL_W = DATA_W / 8;
   localparam int SYNC_STAGES = 3;

   // Register offsets, byte addresses
   localparam logic [ADR_W-1:0] OFS_IRQ_ENABLE_SET = 8'h00;
   localparam logic [ADR_W-1:0] OFS_IRQ_ENABLE_CLEAR = 8'h04;
   localparam logic [ADR_W-1:0] OFS_CLOCK_READY_STATUS = 8'h08;
   localparam logic [ADR_W-1:0] OFS_IRQ_MASK_READBACK = 8'h0C;
   localparam logic [ADR_W-1:0] OFS_READY_EVENT = 8'h10;
   localparam logic [ADR_W-1:0] OFS_OSC_CONFIG = 8'h14;
   localparam logic [ADR_W-1:0] OFS_PLL_CONFIG = 8'h18;

   // Common bit layout of enable, disable, status, mask, event
   localparam int BIT_OSC_STABLE = 0;
   localparam int BIT_PLL_LOCKED = 2;
   localparam int BIT_MASTER_CLOCK_READY = 3;
   localparam int BIT_PROG_CLOCK_READY0 = 8;
   localparam int NUM_PROG_CLOCKS = 3;
   localparam logic [DATA_W-1:0] SRC_BITS = 32'h0000070D;

   // Oscillator configuration fields
   localparam int BIT_OSC_ENABLE = 0;
   localparam int BIT_OSC_BYPASS_A = 1;
   localparam int OSC_COUNT_LSB = 8;
   localparam int OSC_COUNT_W = 8;
   localparam int OSC_COUNT_SHIFT = 3;
   localparam int OSC_TIMER_W = OSC_COUNT_W + OSC_COUNT_SHIFT;
   localparam logic [DATA_W-1:0] OSC_CFG_BITS = 32'h0000FF03;

   // PLL configuration fields
   localparam int PLL_COUNT_LSB = 8;
   localparam int PLL_COUNT_W = 6;
   localparam logic [DATA_W-1:0] PLL_CFG_BITS = 32'h00003F00;

   // Reset values
   localparam logic [DATA_W-1:0] MASK_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] OSC_CFG_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] PLL_CFG_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] EVENT_RESET = 32'h00000000;
   localparam logic [DATA_W-1:0] READ_ZERO = 32'h00000000;

   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [SEL_W-1:0] sel;
      logic [DATA_W-1:0] dat;
   } wb_req_type;

   typedef enum logic [1:0] {
      TMR_IDLE,
      TMR_COUNT,
      TMR_DONE
   } timer_state_type;

   // Byte enables widened to a bit mask
   function automatic logic [DATA_W-1:0] lane_mask(
      input logic [SEL_W-1:0] sel);
      logic [DATA_W-1:0] m;
      m = '0;
      for (int i = 0; i < SEL_W; i++)
      begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return m;
   endfunction

endpackage

// ==== slow_tick_sync.sv ====
// Slow clock synchroniser giving one tick per slow rising edge
`timescale 1ns/1ns
`default_nettype none
module slow_tick_sync
   import clkrdy_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic slow_clk,
   output logic tick
);
   logic [SYNC_STAGES-1:0] sync_q;
   logic level_q;
   logic tick_q;
   logic agree;

   // Only the last two stages are compared, never the first
   assign agree = sync_q[1] == sync_q[2];
   assign tick = tick_q;

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sync_q <= '0;
         level_q <= 1'b0;
         tick_q <= 1'b0;
      end
      else
      begin
         sync_q <= {sync_q[SYNC_STAGES-2:0], slow_clk};
         level_q <= agree ? sync_q[2] : level_q;
         tick_q <= agree & sync_q[2] & ~level_q;
      end
   end
endmodule
`default_nettype wire

// ==== settle_timer.sv ====
// Settling timer counted in slow clock ticks
`timescale 1ns/1ns
`default_nettype none
module settle_timer
   import clkrdy_pkg::*;
#(
   parameter int CNT_W = 11
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic run,
   input wire logic restart,
   input wire logic [CNT_W-1:0] load_value,
   input wire logic tick,
   output logic done
);
   timer_state_type state_q;
   timer_state_type state_d;
   logic [CNT_W-1:0] remain_q;
   logic [CNT_W-1:0] remain_d;

   if (CNT_W < 1)
   begin : g_chk
      $error("settle_timer: CNT_W must be at least 1");
   end

   assign done = state_q == TMR_DONE;

   always_comb
   begin
      state_d = state_q;
      remain_d = remain_q;
      unique case (state_q)
         TMR_IDLE:
         begin
            if (run && restart)
            begin
               state_d = TMR_COUNT;
               remain_d = load_value;
            end
         end
         TMR_COUNT:
         begin
            if (!run)
               state_d = TMR_IDLE;
            else if (restart)
               remain_d = load_value;
            else if (remain_q == '0)
               state_d = TMR_DONE;
            else if (tick)
               remain_d = remain_q - CNT_W'(1);
         end
         TMR_DONE:
         begin
            if (!run)
               state_d = TMR_IDLE;
            else if (restart)
            begin
               state_d = TMR_COUNT;
               remain_d = load_value;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_q <= TMR_IDLE;
         remain_q <= '0;
      end
      else
      begin
         state_q <= state_d;
         remain_q <= remain_d;
      end
   end
endmodule
`default_nettype wire

// ==== clock_ready_status_irq.sv ====
// Clock readiness status, interrupt mask and Wishbone register file
// Summary of operation
// - One bit layout for enable, disable, status, mask and event
// - Enable write sets mask bits written one
// - Disable write clears mask bits written one
// - Mask readback reads zero for enabled source
// - Status bit 0 shows oscillator stabilised
// - Status bit 2 shows PLL locked
// - Status bit 3 shows master clock ready
// - Status bits 8-10 show programmable clocks ready
// - Oscillator stable after startup count times eight
// - Bypass sets stable; clearing both clears it
// - PLL locked after settle count following write
`timescale 1ns/1ns
`default_nettype none
module clock_ready_status_irq
   import clkrdy_pkg::*;
#(
   parameter int MASK_READ_INVERT = 1
)
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [clkrdy_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [clkrdy_pkg::SEL_W-1:0] WB_SEL_I,
   input wire logic [clkrdy_pkg::DATA_W-1:0] WB_DAT_I,
   output logic [clkrdy_pkg::DATA_W-1:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic SLOW_CLK,
   input wire logic MASTER_CLOCK_READY,
   input wire logic [clkrdy_pkg::NUM_PROG_CLOCKS-1:0] PROG_CLOCK_READY,
   output logic IRQ
);
   import clkrdy_pkg::*;

   if (MASK_READ_INVERT != 0 && MASK_READ_INVERT != 1)
   begin : g_chk
      $error("MASK_READ_INVERT must be 0 or 1");
   end

   // Registers reach 0x18, so five address bits at least
   if (ADR_W < 5)
   begin : g_adr_chk
      $error("ADR_W too narrow for the register map");
   end

   if (BIT_PROG_CLOCK_READY0 + NUM_PROG_CLOCKS > DATA_W)
   begin : g_layout_chk
      $error("Programmable clock bits exceed the data word");
   end

   wb_req_type bus;
   logic ack_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic [DATA_W-1:0] mask_q;
   logic [DATA_W-1:0] mask_d;
   logic [DATA_W-1:0] osc_cfg_q;
   logic [DATA_W-1:0] osc_cfg_d;
   logic [DATA_W-1:0] pll_cfg_q;
   logic [DATA_W-1:0] pll_cfg_d;
   logic [DATA_W-1:0] event_q;
   logic [DATA_W-1:0] event_d;
   logic [DATA_W-1:0] status_prev_q;
   logic [DATA_W-1:0] status;
   logic [DATA_W-1:0] rise;
   logic [DATA_W-1:0] wmask;
   logic [DATA_W-1:0] wbits;
   logic [DATA_W-1:0] set_bits;
   logic [DATA_W-1:0] clr_bits;
   logic [DATA_W-1:0] ack_bits;
   logic [DATA_W-1:0] mask_view;
   logic [ADR_W-3:0] word;
   logic access;
   logic wr;
   logic hit_set;
   logic hit_clear;
   logic hit_status;
   logic hit_mask;
   logic hit_event;
   logic hit_osc;
   logic hit_pll;
   logic wr_osc;
   logic wr_pll;
   logic slow_tick;
   logic osc_enable;
   logic osc_bypass_a;
   logic osc_run;
   logic osc_done;
   logic osc_stable;
   logic pll_locked;
   logic [OSC_TIMER_W-1:0] osc_load;
   logic [PLL_COUNT_W-1:0] pll_settle_count;

   // Bus request gathered into one carrier
   assign bus = '{cyc: WB_CYC_I, stb: WB_STB_I, we: WB_WE_I,
                  adr: WB_ADR_I, sel: WB_SEL_I, dat: WB_DAT_I};

   // Ack registered: one wait state, dropped the cycle after
   assign access = bus.cyc & bus.stb & ~ack_q;
   assign wr = access & bus.we;
   assign word = bus.adr[ADR_W-1:2];

   // Word decode shared by every register select
   function automatic logic word_hit(
      input logic [ADR_W-3:0] w,
      input logic [ADR_W-1:0] ofs);
      return w == ofs[ADR_W-1:2];
   endfunction

   assign hit_set = word_hit(word, OFS_IRQ_ENABLE_SET);
   assign hit_clear = word_hit(word, OFS_IRQ_ENABLE_CLEAR);
   assign hit_status = word_hit(word, OFS_CLOCK_READY_STATUS);
   assign hit_mask = word_hit(word, OFS_IRQ_MASK_READBACK);
   assign hit_event = word_hit(word, OFS_READY_EVENT);
   assign hit_osc = word_hit(word, OFS_OSC_CONFIG);
   assign hit_pll = word_hit(word, OFS_PLL_CONFIG);
   assign wr_osc = wr & hit_osc;
   assign wr_pll = wr & hit_pll;

   // Byte enables honoured on every writable register
   assign wmask = lane_mask(bus.sel);
   assign wbits = bus.dat & wmask;

   // Only the defined source bits can be masked
   assign set_bits = (wr & hit_set) ? (wbits & SRC_BITS) : '0;
   assign clr_bits = (wr & hit_clear) ? (wbits & SRC_BITS) : '0;

   // Clear applied last only matters on one address, never both
   assign mask_d = (mask_q | set_bits) & ~clr_bits;

   assign osc_cfg_d = wr_osc
      ? ((osc_cfg_q & ~wmask) | (wbits & OSC_CFG_BITS))
      : osc_cfg_q;
   assign pll_cfg_d = wr_pll
      ? ((pll_cfg_q & ~wmask) | (wbits & PLL_CFG_BITS))
      : pll_cfg_q;

   // Timers take the value being written, so the restart strobe
   // and its count land on one edge rather than the old count
   assign osc_enable = osc_cfg_d[BIT_OSC_ENABLE];
   assign osc_bypass_a = osc_cfg_q[BIT_OSC_BYPASS_A];
   assign osc_run = osc_enable & ~osc_cfg_d[BIT_OSC_BYPASS_A];
   assign osc_load = {osc_cfg_d[OSC_COUNT_LSB +: OSC_COUNT_W],
                      OSC_COUNT_SHIFT'(0)};
   assign pll_settle_count = pll_cfg_d[PLL_COUNT_LSB +: PLL_COUNT_W];

   slow_tick_sync u_tick
   (
      .clk_sys(CLK_SYS),
      .rst_n(RST_N),
      .slow_clk(SLOW_CLK),
      .tick(slow_tick)
   );

   // Timer restarts on the write that lands the new config
   settle_timer #(.CNT_W(OSC_TIMER_W)) u_osc_timer
   (
      .clk_sys(CLK_SYS),
      .rst_n(RST_N),
      .run(osc_run),
      .restart(wr_osc),
      .load_value(osc_load),
      .tick(slow_tick),
      .done(osc_done)
   );

   // Bypass needs no startup wait; clearing both drops stable
   assign osc_stable = osc_bypass_a | osc_done;

   settle_timer #(.CNT_W(PLL_COUNT_W)) u_pll_timer
   (
      .clk_sys(CLK_SYS),
      .rst_n(RST_N),
      .run(1'b1),
      .restart(wr_pll),
      .load_value(pll_settle_count),
      .tick(slow_tick),
      .done(pll_locked)
   );

   // Live readiness levels, reserved bits zero
   always_comb
   begin
      status = '0;
      status[BIT_OSC_STABLE] = osc_stable;
      status[BIT_PLL_LOCKED] = pll_locked;
      status[BIT_MASTER_CLOCK_READY] = MASTER_CLOCK_READY;
      status[BIT_PROG_CLOCK_READY0 +: NUM_PROG_CLOCKS] =
         PROG_CLOCK_READY;
   end

   // Sticky rising-edge events; a new edge beats the clear
   assign rise = status & ~status_prev_q;
   assign ack_bits = (wr & hit_event) ? wbits : '0;
   assign event_d = (event_q & ~ack_bits) | rise;

   // Printed polarity: a one means the source is disabled
   assign mask_view = (MASK_READ_INVERT != 0)
      ? (~mask_q & SRC_BITS)
      : mask_q;

   assign rdata_d =
      hit_status ? status :
      hit_mask ? mask_view :
      hit_event ? event_q :
      hit_osc ? osc_cfg_q :
      hit_pll ? pll_cfg_q :
      READ_ZERO;

   // Level status, not the sticky event, drives the line
   assign IRQ = |(status & mask_q);

   assign WB_ACK_O = ack_q;
   assign WB_DAT_O = rdata_q;

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         ack_q <= 1'b0;
      end
      else
      begin
         ack_q <= access;
      end
   end

   // Zero outside a read answer, so idle data never leaks
   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         rdata_q <= READ_ZERO;
      end
      else
      begin
         rdata_q <= (access & ~bus.we) ? rdata_d : READ_ZERO;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         mask_q <= MASK_RESET;
      end
      else
      begin
         mask_q <= mask_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         osc_cfg_q <= OSC_CFG_RESET;
      end
      else
      begin
         osc_cfg_q <= osc_cfg_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         pll_cfg_q <= PLL_CFG_RESET;
      end
      else
      begin
         pll_cfg_q <= pll_cfg_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         event_q <= EVENT_RESET;
      end
      else
      begin
         event_q <= event_d;
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N)
   begin
      if (!RST_N)
      begin
         status_prev_q <= '0;
      end
      else
      begin
         status_prev_q <= status;
      end
   end
endmodule
`default_nettype wire

// ==== clock_ready_status_irq_checker.sv ====
// Port checks of the clock readiness status block
`timescale 1ns/1ns
`default_nettype none
module clock_ready_status_irq_checker
   import clkrdy_pkg::*;
#(
   parameter int MASK_READ_INVERT = 1
)
(
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [clkrdy_pkg::ADR_W-1:0] WB_ADR_I,
   input wire logic [clkrdy_pkg::SEL_W-1:0] WB_SEL_I,
   input wire logic [clkrdy_pkg::DATA_W-1:0] WB_DAT_I,
   input wire logic [clkrdy_pkg::DATA_W-1:0] WB_DAT_O,
   input wire logic WB_ACK_O,
   input wire logic SLOW_CLK,
   input wire logic MASTER_CLOCK_READY,
   input wire logic [clkrdy_pkg::NUM_PROG_CLOCKS-1:0] PROG_CLOCK_READY,
   input wire logic IRQ
);
   // Mirror assumes full byte lanes on mask writes
   logic [DATA_W-1:0] mask_q;
   logic [DATA_W-1:0] mask_d;
   logic [DATA_W-1:0] mask_rd;
   logic take;
   logic wr;
   logic rd;
   assign take = WB_CYC_I && WB_STB_I && !WB_ACK_O;
   assign wr = take && WB_WE_I;
   assign rd = WB_ACK_O && !WB_WE_I;
   assign mask_d = (wr && WB_ADR_I == OFS_IRQ_ENABLE_SET) ?
      (mask_q | WB_DAT_I) : (wr && WB_ADR_I == OFS_IRQ_ENABLE_CLEAR) ?
      (mask_q & ~WB_DAT_I) : mask_q;
   assign mask_rd = (MASK_READ_INVERT != 0) ? (~mask_q & SRC_BITS) :
      (mask_q & SRC_BITS);
   always_ff @(posedge CLK_SYS or negedge RST_N)
      if (!RST_N)
         mask_q <= MASK_RESET;
      else
         mask_q <= mask_d;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);
   a_ack_after_take: assert property (take |=> WB_ACK_O)
      else $error("no ack after request");
   a_ack_one_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
      else $error("ack longer than one cycle");
   a_dat_idle_zero: assert property (!rd |-> WB_DAT_O == READ_ZERO)
      else $error("read data outside read ack");
   a_mask_read_back: assert property (rd && WB_ADR_I ==
      OFS_IRQ_MASK_READBACK |-> WB_DAT_O == $past(mask_rd))
      else $error("mask readback wrong");
   a_status_ready_in: assert property (rd && WB_ADR_I ==
      OFS_CLOCK_READY_STATUS |-> WB_DAT_O[3] == $past(MASTER_CLOCK_READY)
      && WB_DAT_O[10:8] == $past(PROG_CLOCK_READY))
      else $error("status ready bits wrong");
   a_status_reserved: assert property (rd && WB_ADR_I ==
      OFS_CLOCK_READY_STATUS |-> (WB_DAT_O & ~SRC_BITS) == READ_ZERO)
      else $error("reserved status bit set");
   a_wo_read_zero: assert property (rd && (WB_ADR_I == OFS_IRQ_ENABLE_SET
      || WB_ADR_I == OFS_IRQ_ENABLE_CLEAR) |-> WB_DAT_O == READ_ZERO)
      else $error("write-only register read nonzero");
   a_irq_master_on: assert property (MASTER_CLOCK_READY && mask_q[3]
      |-> IRQ) else $error("irq missing");
   a_irq_all_masked: assert property ((mask_q & SRC_BITS) == 0
      |-> !IRQ) else $error("irq while all masked");
endmodule
bind clock_ready_status_irq clock_ready_status_irq_checker
   #(.MASK_READ_INVERT(MASK_READ_INVERT)) u_clock_ready_status_irq_checker (
   .CLK_SYS(CLK_SYS), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I),
   .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
   .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O),
   .WB_ACK_O(WB_ACK_O), .SLOW_CLK(SLOW_CLK),
   .MASTER_CLOCK_READY(MASTER_CLOCK_READY),
   .PROG_CLOCK_READY(PROG_CLOCK_READY), .IRQ(IRQ));
`default_nettype wire

// ==== slow_clock_src.sv ====
// Slow clock source standing in for the oscillator side
`timescale 1ns/1ns
`default_nettype none
module slow_clock_src
#(
   parameter int HALF_NS = 103
)
(
   output logic slow_clk
);
   logic level = 1'b0;

   // Runs free; 103 ns half period drifts against the bus clock, meeting a bus rising edge every tenth half period
   always #HALF_NS level = ~level;
   assign slow_clk = level;
endmodule
`default_nettype wire

// ==== clock_ready_status_irq_tb_top.sv ====
// Self-checking bench of the clock readiness status block
`timescale 1ns/1ns
`default_nettype none
module clock_ready_status_irq_tb_top;
   import clkrdy_pkg::*;
   typedef struct packed {logic we; logic [ADR_W-1:0] a;
      logic [DATA_W-1:0] d;} row_type;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   wb_req_type req = '0;
   logic [DATA_W-1:0] dat_o;
   logic ack;
   logic slow_clk;
   logic mcr = 1'b0;
   logic [NUM_PROG_CLOCKS-1:0] pcr = '0;
   logic irq;
   int n_errors = 0;
   int checks_done = 0;
   row_type rows [14] = '{
      '{1'b0, 8'h0C, 32'h0000070D},
      '{1'b0, 8'h08, 32'h00000000},
      '{1'b1, 8'h00, 32'h00000008},
      '{1'b0, 8'h0C, 32'h00000705},
      '{1'b1, 8'h00, 32'h00000700},
      '{1'b0, 8'h0C, 32'h00000005},
      '{1'b1, 8'h04, 32'h00000100},
      '{1'b0, 8'h0C, 32'h00000105},
      '{1'b1, 8'h04, 32'hFFFFF8F2},
      '{1'b0, 8'h0C, 32'h00000105},
      '{1'b0, 8'h00, 32'h00000000},
      '{1'b0, 8'h20, 32'h00000000},
      '{1'b1, 8'h08, 32'hFFFFFFFF},
      '{1'b0, 8'h08, 32'h00000000}};
   always #5 clk_sys = ~clk_sys;
   clock_ready_status_irq u_clock_ready_status_irq (.CLK_SYS(clk_sys),
      .RST_N(rst_n), .WB_CYC_I(req.cyc), .WB_STB_I(req.stb),
      .WB_WE_I(req.we), .WB_ADR_I(req.adr), .WB_SEL_I(req.sel),
      .WB_DAT_I(req.dat), .WB_DAT_O(dat_o), .WB_ACK_O(ack),
      .SLOW_CLK(slow_clk), .MASTER_CLOCK_READY(mcr),
      .PROG_CLOCK_READY(pcr), .IRQ(irq));
   slow_clock_src u_slow_clock_src (.slow_clk(slow_clk));
   task automatic chk(input logic [DATA_W-1:0] g, e);
      checks_done++;
      if (g !== e)
      begin
         n_errors++;
         $display("ERROR %0t: got %h want %h", $time, g, e);
      end
   endtask
   task automatic wb(input logic w, input logic [ADR_W-1:0] a,
      input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
      @(posedge clk_sys);
      req <= '{1'b1, 1'b1, w, a, 4'hF, d};
      do
         @(posedge clk_sys);
      while (ack !== 1'b1);
      q = dat_o;
      req <= '0;
   endtask
   task automatic rd(input logic [ADR_W-1:0] a, input logic [DATA_W-1:0] m, e);
      logic [DATA_W-1:0] q;
      wb(1'b0, a, READ_ZERO, q);
      chk(q & m, e);
   endtask
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial
   begin
      #200000;
      n_errors++;
      wrap_up();
   end
   initial
   begin
      logic [DATA_W-1:0] q;
      repeat (10) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (rows[i])
      begin
         wb(rows[i].we, rows[i].a, rows[i].d, q);
         if (!rows[i].we)
            chk(q, rows[i].d);
      end
      $display("register table done");
      mcr <= 1'b1;
      @(posedge clk_sys);
      chk(32'(irq), 32'h1);
      pcr <= 3'b100;
      rd(OFS_CLOCK_READY_STATUS, 32'h0708, 32'h0408);
      wb(1'b1, OFS_IRQ_ENABLE_CLEAR, 32'h0608, q);
      chk(32'(irq), 32'h0);
      rd(OFS_READY_EVENT, 32'h0408, 32'h0408);
      wb(1'b1, OFS_READY_EVENT, 32'h0408, q);
      rd(OFS_READY_EVENT, 32'h0408, 32'h0);
      $display("interrupt test done");
      wb(1'b1, OFS_OSC_CONFIG, 32'h2, q);
      rd(OFS_CLOCK_READY_STATUS, 32'h1, 32'h1);
      wb(1'b1, OFS_OSC_CONFIG, 32'h0, q);
      rd(OFS_CLOCK_READY_STATUS, 32'h1, 32'h0);
      wb(1'b1, OFS_OSC_CONFIG, 32'h101, q);
      repeat (60) @(posedge clk_sys);
      rd(OFS_CLOCK_READY_STATUS, 32'h1, 32'h0);
      repeat (220) @(posedge clk_sys);
      rd(OFS_CLOCK_READY_STATUS, 32'h1, 32'h1);
      $display("oscillator test done");
      wb(1'b1, OFS_PLL_CONFIG, 32'h200, q);
      repeat (100) @(posedge clk_sys);
      rd(OFS_CLOCK_READY_STATUS, 32'h4, 32'h4);
      wb(1'b1, OFS_PLL_CONFIG, 32'h400, q);
      rd(OFS_CLOCK_READY_STATUS, 32'h4, 32'h0);
      repeat (150) @(posedge clk_sys);
      rd(OFS_CLOCK_READY_STATUS, 32'h4, 32'h4);
      $display("pll test done");
      wb(1'b1, OFS_IRQ_ENABLE_SET, 32'h8, q);
      chk(32'(irq), 32'h1);
      rst_n <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      @(posedge clk_sys);
      chk(32'(irq), 32'h0);
      rd(OFS_IRQ_MASK_READBACK, 32'hFFFFFFFF, 32'h0000070D);
      $display("second reset test done");
      wrap_up();
   end
endmodule
`default_nettype wire
